// File: verification/serial_master_chk.sv
`timescale 1ns/1ps

module serial_master_chk (
   input logic core_clk,
   input logic sys_rst,
   input logic serial_memory_mode_select,
   input logic [7:0] baud_div,
   input logic [7:0] deselect_delay,
   input logic [7:0] clock_start_delay,
   input logic [7:0] inter_transfer_delay,
   input logic rx_read,
   input logic status_read,
   input logic [7:0] receive_holding_register,
   input logic transmit_empty_flag,
   input logic tx_dma_request,
   input logic all_transfers_done_flag,
   input logic receive_full_flag,
   input logic overrun_flag,
   input logic serial_chip_select_n,
   input logic serial_clock_out,
   input logic mosi
);
   logic [7:0] hi_cnt;
   logic [9:0] lo_cnt;
   logic [2:0] rises;
   logic seen;
   logic sck_d;
   logic sck_up;
   logic word_edge;
   logic [9:0] start_min;
   logic [9:0] gap_min;
   logic [7:0] rhr;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // short names for the timing and receive checks below
   assign rhr = receive_holding_register;
   assign sck_up = serial_clock_out & ~sck_d;
   assign word_edge = sck_up & seen & (rises == 3'h0) & ~serial_memory_mode_select;
   assign start_min = 10'(clock_start_delay) + 10'(baud_div);
   assign gap_min = 10'(inter_transfer_delay) + 10'(baud_div);

   // high run of chip select; saturates so the first frame after reset passes
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) hi_cnt <= 8'hFF;
      else if (!serial_chip_select_n) hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
   end

   // clock-low run and rising edges inside one frame
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lo_cnt <= 10'h000;
         rises <= 3'h0;
         seen <= 1'b0;
         sck_d <= 1'b0;
      end else begin
         sck_d <= serial_clock_out;
         lo_cnt <= (serial_chip_select_n | serial_clock_out) ? 10'h000 : lo_cnt + 10'h001;
         seen <= ~serial_chip_select_n & (seen | serial_clock_out);
         if (serial_chip_select_n) rises <= 3'h0;
         else if (sck_up) rises <= rises + 3'h1;
      end
   end

   // flags, strobe and serial line timing
   a_dma_follows_empty: assert property (tx_dma_request == transmit_empty_flag)
      else $error("dma request differs from transmit empty");
   a_deselect_min_high: assert property ($fell(serial_chip_select_n) |-> hi_cnt >= deselect_delay)
      else $error("chip select high time too short");
   a_clock_start_wait: assert property (sck_up && !seen |-> lo_cnt >= start_min)
      else $error("first clock edge too early");
   a_word_gap_held: assert property (word_edge |-> lo_cnt >= gap_min)
      else $error("gap between words too short");
   a_idle_clock_low: assert property (serial_chip_select_n |-> !serial_clock_out)
      else $error("clock moves while deselected");
   a_mosi_steady_high: assert property (serial_clock_out && $past(serial_clock_out) |-> $stable(mosi))
      else $error("mosi changed while clock high");
   a_store_sets_full: assert property (!$stable(rhr) |-> receive_full_flag)
      else $error("store without receive full");
   a_read_clears_full: assert property (rx_read ##1 $stable(rhr) |-> !receive_full_flag)
      else $error("receive full kept after read");
   a_unread_sets_overrun: assert property (receive_full_flag && !rx_read ##1 !$stable(rhr) |-> overrun_flag)
      else $error("overrun missed");
   a_status_clears_ovr: assert property (status_read ##1 $stable(rhr) |-> !overrun_flag)
      else $error("overrun kept after status read");
   a_done_low_frame: assert property (!serial_chip_select_n && !serial_memory_mode_select |-> !all_transfers_done_flag)
      else $error("done flag high inside frame");

   // main scenarios reached
   c_word_gap: cover property (word_edge);
   c_overrun: cover property ($rose(overrun_flag));
   c_mem_end: cover property ($rose(serial_chip_select_n) && serial_memory_mode_select);
endmodule : serial_master_chk

bind serial_master serial_master_chk chk (.*);

// File: verification/serial_master_tb.sv
`timescale 1ns/1ps

module serial_master_tb;
   logic core_clk, sys_rst, enable, serial_memory_mode_select, last_transfer_bit, tx_valid, tx_ready;
   logic rx_read, status_read, transmit_empty_flag, tx_dma_request, all_transfers_done_flag;
   logic receive_full_flag, overrun_flag, instruction_end_flag, serial_chip_select_n, serial_clock_out;
   logic mosi, miso, stalled;
   logic [7:0] baud_div, deselect_delay, clock_start_delay, inter_transfer_delay, instruction_code;
   logic [7:0] receive_holding_register, reply_base;
   serial_master_pkg::tx_word_t tx_word;
   int failures, cmp_count, nw;

   serial_master dut (.*);
   spi_slave_model slave (.*);

   // free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic cycles(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cycles

   // valid stays up between words so a back-to-back push never drives twice
   task automatic push(input logic [23:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      tx_valid = 1'b1;
      tx_word = {a, d};
      // ready is read settled, ahead of the edge that takes the word
      while (!tx_ready && n < 2000) begin
         stalled = 1'b1;
         n++;
         @(negedge core_clk);
      end
      @(posedge core_clk);
      check("push", 1, n < 2000);
   endtask : push

   task automatic stop;
      @(negedge core_clk);
      tx_valid = 1'b0;
   endtask : stop

   // bounded wait for a flag to rise
   task automatic await(ref logic f);
      int n;
      n = 0;
      cycles(4);
      while (f !== 1'b1 && n < 5000) begin
         n++;
         @(negedge core_clk);
      end
      check("wait", 1, n < 5000);
   endtask : await

   task automatic pulse(ref logic p);
      @(negedge core_clk);
      p = 1'b1;
      @(negedge core_clk);
      p = 1'b0;
   endtask : pulse

   task automatic t_idle;
      check("idle", 10'h278, {serial_chip_select_n, serial_clock_out, mosi, tx_ready, transmit_empty_flag,
         tx_dma_request, all_transfers_done_flag, receive_full_flag, overrun_flag, instruction_end_flag});
      check("rx reg", 0, receive_holding_register);
      $display("idle test done");
   endtask : t_idle

   task automatic t_single;
      enable = 1'b0;
      push(24'h000000, 8'h3C);
      stop;
      cycles(40);
      check("held off", 1, serial_chip_select_n);
      enable = 1'b1;
      await(receive_full_flag);
      check("in gap", 0, {all_transfers_done_flag, serial_chip_select_n});
      await(all_transfers_done_flag);
      check("tx word", 8'h3C, slave.seen[nw]);
      check("rx word", 8'(reply_base + nw), receive_holding_register);
      check("flags", 3'b110, {receive_full_flag, transmit_empty_flag, overrun_flag});
      nw++;
      pulse(rx_read);
      check("full clr", 0, receive_full_flag);
      $display("single word test done");
   endtask : t_single

   task automatic t_burst;
      int k;
      stalled = 1'b0;
      for (k = 0; k < 7; k++) push(24'h000000, 8'h80 + k[7:0]);
      stop;
      check("refused", 1, stalled);
      check("empty clr", 0, transmit_empty_flag);
      await(all_transfers_done_flag);
      for (k = 0; k < 7; k++) check("burst tx", 8'(8'h80 + k), slave.seen[nw + k]);
      nw += 7;
      check("rx last", 8'(reply_base + nw - 1), receive_holding_register);
      check("overrun", 1, overrun_flag);
      pulse(status_read);
      check("ovr clr", 0, overrun_flag);
      pulse(rx_read);
      $display("burst test done");
   endtask : t_burst

   task automatic t_mem;
      int k;
      logic [7:0] exp [0:5];
      exp = '{8'h02, 8'h12, 8'h34, 8'h56, 8'hD0, 8'hD1};
      k = 0;
      // code set before the frame opens
      instruction_code = 8'h02;
      serial_memory_mode_select = 1'b1;
      inter_transfer_delay = 8'h00;
      push(24'h123456, 8'hD0);
      push(24'h000777, 8'hD1);
      stop;
      while (slave.count < nw + 6 && k < 3000) begin
         k++;
         @(negedge core_clk);
      end
      cycles(8);
      check("cs held", 0, serial_chip_select_n);
      pulse(last_transfer_bit);
      await(instruction_end_flag);
      await(all_transfers_done_flag);
      check("cs idle", 1, serial_chip_select_n);
      for (k = 0; k < 6; k++) check("mem frame", exp[k], slave.seen[nw + k]);
      nw += 6;
      pulse(status_read);
      check("end clr", 0, instruction_end_flag);
      serial_memory_mode_select = 1'b0;
      $display("memory test done");
   endtask : t_mem

   task automatic t_abort;
      push(24'h000000, 8'h5A);
      stop;
      cycles(30);
      sys_rst = 1'b1;
      cycles(2);
      sys_rst = 1'b0;
      cycles(1);
      t_idle;
      $display("abort test done");
   endtask : t_abort

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // main sequence
   initial begin
      sys_rst = 1'b1;
      enable = 1'b1;
      serial_memory_mode_select = 1'b0;
      baud_div = 8'h03;
      deselect_delay = 8'h06;
      clock_start_delay = 8'h03;
      inter_transfer_delay = 8'h14;
      instruction_code = 8'h02;
      last_transfer_bit = 1'b0;
      tx_valid = 1'b0;
      tx_word = '0;
      rx_read = 1'b0;
      status_read = 1'b0;
      reply_base = 8'h40;
      failures = 0;
      cmp_count = 0;
      nw = 0;
      cycles(4);
      sys_rst = 1'b0;
      t_idle;
      t_single;
      t_burst;
      t_mem;
      t_abort;
      give_verdict;
   end

   // hang guard, well beyond the little over a thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      $display("BAD watchdog expected end seen hang");
      give_verdict;
   end
endmodule : serial_master_tb

// File: verification/spi_slave_model.sv
`timescale 1ns/1ps

module spi_slave_model (
   input logic serial_chip_select_n,
   input logic serial_clock_out,
   input logic mosi,
   input logic [7:0] reply_base,
   output logic miso
);
   logic [7:0] rx_sh;
   logic [7:0] tx_sh;
   logic [7:0] seen [0:63];
   int bits;
   int count;

   initial begin
      miso = 1'b0;
      bits = 0;
      count = 0;
   end

   // each word answers base plus its index, so every store differs
   always @(negedge serial_chip_select_n) begin
      bits = 0;
      tx_sh = reply_base + 8'(count);
      miso = tx_sh[7];
   end

   // released line has no pull, so show the inverse of the last bit
   always @(posedge serial_chip_select_n) miso = ~miso;

   // sample on the rising edge, msb first
   always @(posedge serial_clock_out) begin
      if (!serial_chip_select_n) begin
         rx_sh = {rx_sh[6:0], mosi};
         bits = bits + 1;
         if (bits == 8) begin
            seen[count[5:0]] = rx_sh;
            count = count + 1;
            bits = 0;
         end
      end
   end

   // next bit on the falling edge
   always @(negedge serial_clock_out) begin
      if (!serial_chip_select_n) begin
         tx_sh = (bits == 0) ? reply_base + 8'(count) : {tx_sh[6:0], 1'b0};
         miso = tx_sh[7];
      end
   end
endmodule : spi_slave_model

// File: verilog/serial_master.sv
`timescale 1ns/1ps

`include "serial_master_params.svh"

module serial_master (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic serial_memory_mode_select,
   input wire logic [`SM_BAUD_W-1:0] baud_div,
   input wire logic [`SM_DLY_W-1:0] deselect_delay,
   input wire logic [`SM_DLY_W-1:0] clock_start_delay,
   input wire logic [`SM_DLY_W-1:0] inter_transfer_delay,
   input wire logic [`SM_WORD_W-1:0] instruction_code,
   input wire logic last_transfer_bit,
   input wire logic tx_valid,
   input wire serial_master_pkg::tx_word_t tx_word,
   output logic tx_ready,
   input wire logic rx_read,
   input wire logic status_read,
   output logic [`SM_WORD_W-1:0] receive_holding_register,
   output logic transmit_empty_flag,
   output logic tx_dma_request,
   output logic all_transfers_done_flag,
   output logic receive_full_flag,
   output logic overrun_flag,
   output logic instruction_end_flag,
   output logic serial_chip_select_n,
   output logic serial_clock_out,
   output logic mosi,
   input wire logic miso
);

   serial_master_pkg::engine_state_t state_reg;
   serial_master_pkg::tx_word_t fifo_word;
   serial_master_pkg::tx_word_t hold_reg;
   logic fifo_valid;
   logic hold_full_reg;
   logic miso_meta_reg;
   logic miso_sync_reg;
   logic miso_bit_reg;
   logic [`SM_WORD_W-1:0] shift_reg;
   logic [`SM_WORD_W-1:0] next_byte;
   logic [`SM_ADDR_W-1:0] frame_addr_reg;
   logic [`SM_HDR_W-1:0] hdr_idx_reg;
   logic [`SM_DLY_W-1:0] dly_reg;
   logic [`SM_BAUD_W-1:0] baud_reg;
   logic [`SM_HALF_W-1:0] half_reg;
   logic last_pend_reg;
   logic baud_tick;
   logic hdr_phase;
   logic word_ready;
   logic load_now;
   logic word_done;
   logic dly_zero;
   logic end_frame;

   // the fifo absorbs bursts ahead of the holding register
   word_fifo #(
      .WIDTH($bits(serial_master_pkg::tx_word_t)),
      .DEPTH(`SM_FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_word),
      .out_valid(fifo_valid),
      .out_ready(!hold_full_reg),
      .out_data(fifo_word)
   );

   // header bytes of a memory instruction, address first write's
   function automatic logic [`SM_WORD_W-1:0] header_byte(
      input logic [`SM_HDR_W-1:0] idx,
      input logic [`SM_WORD_W-1:0] code,
      input logic [`SM_ADDR_W-1:0] addr
   );
      unique case (idx)
         3'h0: header_byte = code;
         3'h1: header_byte = addr[23:16];
         3'h2: header_byte = addr[15:8];
         default: header_byte = addr[7:0];
      endcase
   endfunction : header_byte

   // memory mode sends the instruction header before any data word
   assign hdr_phase = serial_memory_mode_select && (hdr_idx_reg != `SM_HDR_BYTES);
   assign word_ready = hdr_phase || hold_full_reg;
   assign next_byte = hdr_phase ?
      header_byte(hdr_idx_reg, instruction_code, frame_addr_reg) : hold_reg.data;
   assign dly_zero = (dly_reg <= `SM_DLY_ONE);
   assign baud_tick = (baud_reg == '0);
   assign word_done = (state_reg == serial_master_pkg::ST_SHIFT) && baud_tick
      && (half_reg == `SM_HALF_PERIODS - 1'b1);

   // a word is loaded when a delay has run out and one is waiting
   always_comb begin
      load_now = 1'b0;
      end_frame = 1'b0;
      unique case (state_reg)
         serial_master_pkg::ST_SETUP: begin
            load_now = dly_zero;
         end
         serial_master_pkg::ST_GAP: begin
            load_now = dly_zero && word_ready;
            end_frame = dly_zero && !word_ready
               && (!serial_memory_mode_select || last_pend_reg);
         end
         serial_master_pkg::ST_IDLE,
         serial_master_pkg::ST_SHIFT,
         serial_master_pkg::ST_DESELECT: begin
            load_now = 1'b0;
         end
      endcase
   end

   // two flops before the pin is looked at
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         miso_meta_reg <= 1'b0;
         miso_sync_reg <= 1'b0;
      end else begin
         miso_meta_reg <= miso;
         miso_sync_reg <= miso_meta_reg;
      end
   end

   // holding register refills from the fifo whenever it has been taken
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_reg <= '0;
         hold_full_reg <= 1'b0;
         transmit_empty_flag <= 1'b1;
         tx_dma_request <= 1'b1;
      end else if (load_now && !hdr_phase) begin
         hold_full_reg <= 1'b0;
         transmit_empty_flag <= 1'b1;
         tx_dma_request <= 1'b1;
      end else if (!hold_full_reg && fifo_valid) begin
         hold_reg <= fifo_word;
         hold_full_reg <= 1'b1;
         transmit_empty_flag <= 1'b0;
         tx_dma_request <= 1'b0;
      end
   end

   // main sequence: setup, shift, gap, deselect
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= serial_master_pkg::ST_IDLE;
         dly_reg <= '0;
      end else begin
         unique case (state_reg)
            serial_master_pkg::ST_IDLE: begin
               if (enable && hold_full_reg) begin
                  state_reg <= serial_master_pkg::ST_SETUP;
                  dly_reg <= clock_start_delay;
               end
            end
            serial_master_pkg::ST_SETUP: begin
               if (load_now) begin
                  state_reg <= serial_master_pkg::ST_SHIFT;
               end else begin
                  dly_reg <= dly_reg - 1'b1;
               end
            end
            serial_master_pkg::ST_SHIFT: begin
               if (word_done) begin
                  state_reg <= serial_master_pkg::ST_GAP;
                  if (serial_memory_mode_select) begin
                     dly_reg <= '0;
                  end else begin
                     dly_reg <= inter_transfer_delay;
                  end
               end
            end
            serial_master_pkg::ST_GAP: begin
               if (load_now) begin
                  state_reg <= serial_master_pkg::ST_SHIFT;
               end else if (end_frame) begin
                  state_reg <= serial_master_pkg::ST_DESELECT;
                  dly_reg <= deselect_delay;
               end else if (!dly_zero) begin
                  dly_reg <= dly_reg - 1'b1;
               end
            end
            serial_master_pkg::ST_DESELECT: begin
               if (dly_zero) begin
                  state_reg <= serial_master_pkg::ST_IDLE;
               end else begin
                  dly_reg <= dly_reg - 1'b1;
               end
            end
         endcase
      end
   end

   // baud generator runs only while shifting, restarted at each load
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         baud_reg <= '0;
         half_reg <= '0;
      end else if (load_now || state_reg != serial_master_pkg::ST_SHIFT) begin
         baud_reg <= baud_div;
         half_reg <= '0;
      end else if (baud_tick) begin
         baud_reg <= baud_div;
         half_reg <= half_reg + 1'b1;
      end else begin
         baud_reg <= baud_reg - 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_chip_select_n <= `SM_CS_IDLE;
         serial_clock_out <= `SM_SCK_IDLE;
      end else begin
         if (state_reg == serial_master_pkg::ST_IDLE && enable && hold_full_reg) begin
            serial_chip_select_n <= ~`SM_CS_IDLE;
         end else if (end_frame) begin
            serial_chip_select_n <= `SM_CS_IDLE;
         end
         if (state_reg == serial_master_pkg::ST_SHIFT && baud_tick && !load_now) begin
            serial_clock_out <= ~serial_clock_out;
         end else if (state_reg != serial_master_pkg::ST_SHIFT) begin
            serial_clock_out <= `SM_SCK_IDLE;
         end
      end
   end

   // mode 0: sample on rising edge, shift on falling edge
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= `SM_WORD_RST;
         miso_bit_reg <= 1'b0;
         mosi <= 1'b0;
      end else if (load_now) begin
         shift_reg <= next_byte;
         mosi <= next_byte[`SM_WORD_W-1];
      end else if (state_reg == serial_master_pkg::ST_SHIFT && baud_tick) begin
         if (!half_reg[0]) begin
            miso_bit_reg <= miso_sync_reg;
         end else begin
            shift_reg <= {shift_reg[`SM_WORD_W-2:0], miso_bit_reg};
            mosi <= shift_reg[`SM_WORD_W-2];
         end
      end
   end

   // header progress and the first-write address of a memory instruction
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hdr_idx_reg <= '0;
         frame_addr_reg <= '0;
      end else if (state_reg == serial_master_pkg::ST_IDLE) begin
         hdr_idx_reg <= '0;
         frame_addr_reg <= hold_reg.addr;
      end else if (load_now && hdr_phase) begin
         hdr_idx_reg <= hdr_idx_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_pend_reg <= 1'b0;
      end else if (last_transfer_bit) begin
         last_pend_reg <= 1'b1;
      end else if (end_frame) begin
         last_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         all_transfers_done_flag <= 1'b1;
      end else if (state_reg == serial_master_pkg::ST_IDLE && enable && hold_full_reg) begin
         all_transfers_done_flag <= 1'b0;
      end else if (end_frame) begin
         all_transfers_done_flag <= 1'b1;
      end
   end

   // received word lands in the holding register at word end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         receive_holding_register <= `SM_WORD_RST;
      end else if (word_done) begin
         receive_holding_register <= {shift_reg[`SM_WORD_W-2:0], miso_bit_reg};
      end
   end

   // receive flags; a store in the clearing cycle wins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         receive_full_flag <= 1'b0;
         overrun_flag <= 1'b0;
      end else begin
         if (word_done) begin
            receive_full_flag <= 1'b1;
         end else if (rx_read) begin
            receive_full_flag <= 1'b0;
         end
         if (word_done && receive_full_flag && !rx_read) begin
            overrun_flag <= 1'b1;
         end else if (status_read) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   // instruction end is sticky until status is read
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         instruction_end_flag <= 1'b0;
      end else if (end_frame && serial_memory_mode_select) begin
         instruction_end_flag <= 1'b1;
      end else if (status_read) begin
         instruction_end_flag <= 1'b0;
      end
   end

endmodule : serial_master

// File: verilog/serial_master_params.svh
`ifndef SERIAL_MASTER_PARAMS_SVH
`define SERIAL_MASTER_PARAMS_SVH

// serial word and memory address widths
`define SM_WORD_W 8
`define SM_ADDR_W 24
// delay and baud fields count core_clk cycles
`define SM_DLY_W 8
`define SM_BAUD_W 8
// transmit fifo depth
`define SM_FIFO_DEPTH 4
// serial-memory header: code byte plus three address bytes
`define SM_HDR_BYTES 3'h4
`define SM_HDR_W 3
// half serial clock periods per word
`define SM_HALF_PERIODS 5'h10
`define SM_HALF_W 5
// idle levels and reset values
`define SM_CS_IDLE 1'b1
`define SM_SCK_IDLE 1'b0
`define SM_WORD_RST 8'h00
`define SM_DLY_ONE 8'h01

`endif

// File: verilog/serial_master_pkg.sv
package serial_master_pkg;

   // one queued transmit word with the system-bus address it came with
   typedef struct packed {
      logic [23:0] addr;
      logic [7:0] data;
   } tx_word_t;

   // serial engine sequence
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_SHIFT,
      ST_GAP,
      ST_DESELECT
   } engine_state_t;

endpackage : serial_master_pkg

// File: verilog/word_fifo.sv
`timescale 1ns/1ps

module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic [PW:0] count_next;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg];

   // occupancy after this cycle's push and pop
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // storage is not reset; only words below count are ever shown
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
      end
   end

   // full and empty kept as flops so both ready and valid are registered
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         in_ready <= (count_next != (PW + 1)'(DEPTH));
         out_valid <= (count_next != '0);
      end
   end

endmodule : word_fifo
